// file: rtl/dcf_regs.vh
`ifndef DCF_REGS_VH
`define DCF_REGS_VH

// data word width
`define DCF_DATA_W 9
// log2 of channel depth: 8,9,10,11,12 give 256..4096 words
`define DCF_ADDR_W 8
// offset register width and count
`define DCF_OFS_W 8
`define DCF_OFS_SEL_W 2
// offset register load sequence
`define DCF_SEL_EMPTY_LO 2'h0
`define DCF_SEL_EMPTY_HI 2'h1
`define DCF_SEL_FULL_LO 2'h2
`define DCF_SEL_FULL_HI 2'h3
// default offsets after reset
`define DCF_EMPTY_LO_RST 8'h07
`define DCF_EMPTY_HI_RST 8'h00
`define DCF_FULL_LO_RST 8'h07
`define DCF_FULL_HI_RST 8'h00
// flag levels while reset is held (active low flags)
`define DCF_FULL_N_RST 1'h1
`define DCF_AFULL_N_RST 1'h1
`define DCF_EMPTY_N_RST 1'h0
`define DCF_AEMPTY_N_RST 1'h0
`define DCF_OUT_RST 9'h000

`endif

// file: rtl/dcf_top.v
//Behaviour
//- two identical independent channels, each with own data, clocks, enables, reset, flags.
//- each channel takes nine-bit input words.
//- channel reset low returns read and write pointers to first location.
//- reset drives full and almost-full high, empty and almost-empty low.
//- reset zeroes the output register and restores default flag offsets.
//- writes start on write clock rise; full flags update on write clock.
//- works with asynchronous or identical read and write clocks.
//- flag mode: first write enable low with load pin high qualifies one stored word per edge.
//- unqualified write leaves input register and array untouched.
//- full drives full flag low, ignores writes; a read releases it.
//- both read enables low move next word into output register.
//- either read enable high keeps the output register unchanged.
//- empty drives empty flag low, ignores reads; a write releases it.
//- empty and almost-empty update on read clock rise.
//- output enable low drives output register; high floats data bus.
//- dual pin high during reset selects two-write-enable mode.
//- two-enable mode stores when first enable low and second high.
//- two-enable mode holds input when first high or second low.
//- dual pin low during reset selects flag mode; pin becomes offset load.
//- load writes empty low, empty high, full low, full high, then wraps.
//- almost-empty low while count at most empty offset; default seven.
//- almost-full low when count reaches depth minus full offset; default seven.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "dcf_regs.vh"
`default_nettype none

module dcf_channel (
    input wire clock,
    input wire reset,
    input wire wr_clk,
    input wire rd_clk,
    input wire chan_reset_n,
    input wire [`DCF_DATA_W-1:0] wr_data_in,
    input wire wr_en_first_n,
    input wire wr_en_second_or_load,
    input wire rd_en_first_n,
    input wire rd_en_second_n,
    input wire out_drive_en_n,
    output reg [`DCF_DATA_W-1:0] rd_data_out,
    output reg rd_data_oe,
    output reg empty_flag_n,
    output reg full_flag_n,
    output reg almost_empty_flag_n,
    output reg almost_full_flag_n
);
    localparam AW = `DCF_ADDR_W;
    localparam DEPTH = 1 << AW;

    // link clocks are plain synchronous inputs; their rising edges become enables
    reg wr_clk_q;
    reg rd_clk_q;
    reg two_wen_mode;
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    reg [`DCF_DATA_W-1:0] out_reg;
    reg [`DCF_DATA_W-1:0] mem [0:DEPTH-1];
    reg [`DCF_OFS_W-1:0] empty_lo;
    reg [`DCF_OFS_W-1:0] empty_hi;
    reg [`DCF_OFS_W-1:0] full_lo;
    reg [`DCF_OFS_W-1:0] full_hi;
    reg [`DCF_OFS_SEL_W-1:0] ofs_sel;

    wire wr_edge = wr_clk & ~wr_clk_q;
    wire rd_edge = rd_clk & ~rd_clk_q;
    wire [AW:0] count = wr_ptr - rd_ptr;
    wire [AW:0] depth_val = {1'b1, {AW{1'b0}}};
    wire is_full = (count == depth_val);
    wire is_empty = (count == {(AW+1){1'b0}});
    wire [15:0] empty_ofs16 = {empty_hi, empty_lo};
    wire [15:0] full_ofs16 = {full_hi, full_lo};
    wire [AW:0] empty_ofs = {1'b0, empty_ofs16[AW-1:0]};
    wire [AW:0] full_ofs = {1'b0, full_ofs16[AW-1:0]};
    wire [AW:0] afull_level = depth_val - full_ofs;

    // flag mode: second pin is the load enable, low means offset load
    wire wr_qual = two_wen_mode ? (~wr_en_first_n & wr_en_second_or_load)
                                : (~wr_en_first_n & wr_en_second_or_load);
    wire ofs_load = ~two_wen_mode & ~wr_en_first_n & ~wr_en_second_or_load;
    // full ignores all write enables, the load path included
    wire wr_do = chan_reset_n & wr_edge & wr_qual & ~is_full;
    wire ofs_do = chan_reset_n & wr_edge & ofs_load & ~is_full;
    wire rd_do = chan_reset_n & rd_edge & ~rd_en_first_n & ~rd_en_second_n & ~is_empty;

    // a same-cycle write and read is correct for coincident clocks too
    wire [AW:0] next_count = count + {{AW{1'b0}}, wr_do} - {{AW{1'b0}}, rd_do};

    always @(posedge clock) begin
        if (wr_do) begin
            mem[wr_ptr[AW-1:0]] <= wr_data_in;
        end
    end

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_clk_q <= 1'b0;
            rd_clk_q <= 1'b0;
            two_wen_mode <= 1'b0;
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
            out_reg <= `DCF_OUT_RST;
            empty_lo <= `DCF_EMPTY_LO_RST;
            empty_hi <= `DCF_EMPTY_HI_RST;
            full_lo <= `DCF_FULL_LO_RST;
            full_hi <= `DCF_FULL_HI_RST;
            ofs_sel <= `DCF_SEL_EMPTY_LO;
            full_flag_n <= `DCF_FULL_N_RST;
            almost_full_flag_n <= `DCF_AFULL_N_RST;
            empty_flag_n <= `DCF_EMPTY_N_RST;
            almost_empty_flag_n <= `DCF_AEMPTY_N_RST;
            rd_data_out <= `DCF_OUT_RST;
            rd_data_oe <= 1'b0;
        end else begin
            wr_clk_q <= wr_clk;
            rd_clk_q <= rd_clk;
            rd_data_out <= out_reg;
            rd_data_oe <= ~out_drive_en_n;
            if (!chan_reset_n) begin
                two_wen_mode <= wr_en_second_or_load;
                wr_ptr <= {(AW+1){1'b0}};
                rd_ptr <= {(AW+1){1'b0}};
                out_reg <= `DCF_OUT_RST;
                empty_lo <= `DCF_EMPTY_LO_RST;
                empty_hi <= `DCF_EMPTY_HI_RST;
                full_lo <= `DCF_FULL_LO_RST;
                full_hi <= `DCF_FULL_HI_RST;
                ofs_sel <= `DCF_SEL_EMPTY_LO;
                full_flag_n <= `DCF_FULL_N_RST;
                almost_full_flag_n <= `DCF_AFULL_N_RST;
                empty_flag_n <= `DCF_EMPTY_N_RST;
                almost_empty_flag_n <= `DCF_AEMPTY_N_RST;
            end else begin
                if (wr_do) begin
                    wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
                end
                if (rd_do) begin
                    out_reg <= mem[rd_ptr[AW-1:0]];
                    rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
                end
                if (ofs_do) begin
                    case (ofs_sel)
                        `DCF_SEL_EMPTY_LO: empty_lo <= wr_data_in[`DCF_OFS_W-1:0];
                        `DCF_SEL_EMPTY_HI: empty_hi <= wr_data_in[`DCF_OFS_W-1:0];
                        `DCF_SEL_FULL_LO: full_lo <= wr_data_in[`DCF_OFS_W-1:0];
                        `DCF_SEL_FULL_HI: full_hi <= wr_data_in[`DCF_OFS_W-1:0];
                        default: empty_lo <= empty_lo;
                    endcase
                    ofs_sel <= ofs_sel + 2'h1;
                end
                // write-side flags only move on a write clock edge
                if (wr_edge) begin
                    full_flag_n <= ~(next_count == depth_val);
                    almost_full_flag_n <= ~(next_count >= afull_level);
                end
                // read-side flags only move on a read clock edge
                if (rd_edge) begin
                    empty_flag_n <= (next_count != {(AW+1){1'b0}});
                    almost_empty_flag_n <= ~(next_count <= empty_ofs);
                end
            end
        end
    end
endmodule

module dcf_top (
    input wire clock,
    input wire reset,
    input wire wr_clk_a,
    input wire rd_clk_a,
    input wire chan_reset_n_a,
    input wire [`DCF_DATA_W-1:0] wr_data_in_a,
    input wire wr_en_first_n_a,
    input wire wr_en_second_or_load_a,
    input wire rd_en_first_n_a,
    input wire rd_en_second_n_a,
    input wire out_drive_en_n_a,
    output wire [`DCF_DATA_W-1:0] rd_data_out_a,
    output wire rd_data_oe_a,
    output wire empty_flag_n_a,
    output wire full_flag_n_a,
    output wire almost_empty_flag_n_a,
    output wire almost_full_flag_n_a,
    input wire wr_clk_b,
    input wire rd_clk_b,
    input wire chan_reset_n_b,
    input wire [`DCF_DATA_W-1:0] wr_data_in_b,
    input wire wr_en_first_n_b,
    input wire wr_en_second_or_load_b,
    input wire rd_en_first_n_b,
    input wire rd_en_second_n_b,
    input wire out_drive_en_n_b,
    output wire [`DCF_DATA_W-1:0] rd_data_out_b,
    output wire rd_data_oe_b,
    output wire empty_flag_n_b,
    output wire full_flag_n_b,
    output wire almost_empty_flag_n_b,
    output wire almost_full_flag_n_b
);
    // two channels share nothing but the system clock and reset
    dcf_channel u_chan_a (
        .clock(clock),
        .reset(reset),
        .wr_clk(wr_clk_a),
        .rd_clk(rd_clk_a),
        .chan_reset_n(chan_reset_n_a),
        .wr_data_in(wr_data_in_a),
        .wr_en_first_n(wr_en_first_n_a),
        .wr_en_second_or_load(wr_en_second_or_load_a),
        .rd_en_first_n(rd_en_first_n_a),
        .rd_en_second_n(rd_en_second_n_a),
        .out_drive_en_n(out_drive_en_n_a),
        .rd_data_out(rd_data_out_a),
        .rd_data_oe(rd_data_oe_a),
        .empty_flag_n(empty_flag_n_a),
        .full_flag_n(full_flag_n_a),
        .almost_empty_flag_n(almost_empty_flag_n_a),
        .almost_full_flag_n(almost_full_flag_n_a)
    );

    dcf_channel u_chan_b (
        .clock(clock),
        .reset(reset),
        .wr_clk(wr_clk_b),
        .rd_clk(rd_clk_b),
        .chan_reset_n(chan_reset_n_b),
        .wr_data_in(wr_data_in_b),
        .wr_en_first_n(wr_en_first_n_b),
        .wr_en_second_or_load(wr_en_second_or_load_b),
        .rd_en_first_n(rd_en_first_n_b),
        .rd_en_second_n(rd_en_second_n_b),
        .out_drive_en_n(out_drive_en_n_b),
        .rd_data_out(rd_data_out_b),
        .rd_data_oe(rd_data_oe_b),
        .empty_flag_n(empty_flag_n_b),
        .full_flag_n(full_flag_n_b),
        .almost_empty_flag_n(almost_empty_flag_n_b),
        .almost_full_flag_n(almost_full_flag_n_b)
    );
endmodule

`default_nettype wire

// file: test/dcf_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcf_regs.vh"
module dcf_props (
    input wire clock,
    input wire reset,
    input wire wr_clk_a,
    input wire rd_clk_a,
    input wire chan_reset_n_a,
    input wire rd_en_first_n_a,
    input wire rd_en_second_n_a,
    input wire out_drive_en_n_a,
    input wire [`DCF_DATA_W-1:0] rd_data_out_a,
    input wire rd_data_oe_a,
    input wire empty_flag_n_a,
    input wire full_flag_n_a,
    input wire almost_empty_flag_n_a,
    input wire almost_full_flag_n_a
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    // two low samples: the first clears the register, the second copies it out
    sequence ch_rst;
        !chan_reset_n_a ##1 !chan_reset_n_a;
    endsequence
    rst_flags_a: assert property (
        !chan_reset_n_a |=> full_flag_n_a && almost_full_flag_n_a && !empty_flag_n_a && !almost_empty_flag_n_a)
        else $error("flags off reset levels");
    out_clear_a: assert property (ch_rst |=> rd_data_out_a == 9'h000)
        else $error("output not cleared");
    oe_follow_a: assert property (!$past(reset) |-> rd_data_oe_a == !$past(out_drive_en_n_a))
        else $error("output enable wrong");
    empty_sync_a: assert property (
        chan_reset_n_a && !(rd_clk_a && !$past(rd_clk_a))
        |=> $stable(empty_flag_n_a) && $stable(almost_empty_flag_n_a))
        else $error("empty flags moved off read clock");
    full_sync_a: assert property (
        chan_reset_n_a && !(wr_clk_a && !$past(wr_clk_a))
        |=> $stable(full_flag_n_a) && $stable(almost_full_flag_n_a))
        else $error("full flags moved off write clock");
    out_hold_a: assert property (
        chan_reset_n_a && !(rd_clk_a && !$past(rd_clk_a) && !rd_en_first_n_a && !rd_en_second_n_a)
        |-> ##2 $stable(rd_data_out_a))
        else $error("output changed without read");
    aempty_imp_a: assert property (!empty_flag_n_a |-> !almost_empty_flag_n_a)
        else $error("empty without almost empty");
    afull_imp_a: assert property (!full_flag_n_a |-> !almost_full_flag_n_a)
        else $error("full without almost full");
endmodule
bind dcf_top dcf_props u_dcf_props (.clock, .reset, .wr_clk_a, .rd_clk_a, .chan_reset_n_a, .rd_en_first_n_a,
    .rd_en_second_n_a, .out_drive_en_n_a, .rd_data_out_a, .rd_data_oe_a, .empty_flag_n_a, .full_flag_n_a,
    .almost_empty_flag_n_a, .almost_full_flag_n_a);
`default_nettype wire

// file: test/dcf_peer.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_peer (
    input wire logic clock,
    output logic wr_clk,
    output logic [8:0] wr_data,
    output logic wr_first_n,
    output logic wr_second,
    output logic rd_clk,
    output logic rd_first_n,
    output logic rd_second_n
);
    initial begin
        {wr_clk, rd_clk, wr_data, wr_first_n, wr_second, rd_first_n, rd_second_n} = 15'h0000;
    end
    task wr(input logic [8:0] d, input logic f, input logic s);
        @(posedge clock);
        wr_clk <= 1'h1;
        wr_data <= d;
        wr_first_n <= f;
        wr_second <= s;
        @(posedge clock);
        wr_clk <= 1'h0;
        // released data shows the inverse so a late sample cannot pass by luck
        wr_data <= ~d;
    endtask
    task rd(input logic f, input logic s);
        @(posedge clock);
        rd_clk <= 1'h1;
        rd_first_n <= f;
        rd_second_n <= s;
        @(posedge clock);
        rd_clk <= 1'h0;
    endtask
    task pin(input logic v);
        wr_second <= v;
    endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic crn = 1'h1;
    logic crn_b = 1'h0;
    logic oen = 1'h1;
    wire wc, rc, wf, ws, rf, rs, oe, ef, ff, ae, af, ef_b;
    wire [8:0] wd, q;
    int err_count = 0;
    int num_checks = 0;
    always #10 clock = ~clock;
    dcf_peer u_dcf_peer (.clock(clock), .wr_clk(wc), .wr_data(wd), .wr_first_n(wf), .wr_second(ws),
        .rd_clk(rc), .rd_first_n(rf), .rd_second_n(rs));
    dcf_top u_dcf_top (.clock(clock), .reset(reset), .wr_clk_a(wc), .rd_clk_a(rc), .chan_reset_n_a(crn),
        .wr_data_in_a(wd), .wr_en_first_n_a(wf), .wr_en_second_or_load_a(ws), .rd_en_first_n_a(rf),
        .rd_en_second_n_a(rs), .out_drive_en_n_a(oen), .rd_data_out_a(q), .rd_data_oe_a(oe),
        .empty_flag_n_a(ef), .full_flag_n_a(ff), .almost_empty_flag_n_a(ae), .almost_full_flag_n_a(af),
        .wr_clk_b(wc), .rd_clk_b(wc), .chan_reset_n_b(crn_b), .wr_data_in_b(wd), .wr_en_first_n_b(wf),
        .wr_en_second_or_load_b(ws), .rd_en_first_n_b(rf), .rd_en_second_n_b(rs), .out_drive_en_n_b(oen),
        .rd_data_out_b(), .rd_data_oe_b(), .empty_flag_n_b(ef_b), .full_flag_n_b(),
        .almost_empty_flag_n_b(), .almost_full_flag_n_b());
    task chk(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task settle;
        @(posedge clock);
        #1;
    endtask
    task t_reset(input logic mode);
        @(posedge clock);
        u_dcf_peer.pin(mode);
        crn <= 1'h0;
        repeat (3) @(posedge clock);
        crn <= 1'h1;
        settle();
        chk({5'h00, ff, af, ef, ae}, 9'h00C);
        chk(q, 9'h000);
    endtask
    task t_twoen;
        t_reset(1'h1);
        u_dcf_peer.wr(9'h1A5, 1'h0, 1'h1);
        settle();
        chk({7'h00, ef, ef_b}, 9'h001);
        u_dcf_peer.wr(9'h0F0, 1'h1, 1'h1);
        u_dcf_peer.wr(9'h00F, 1'h0, 1'h0);
        u_dcf_peer.wr(9'h05A, 1'h0, 1'h1);
        u_dcf_peer.rd(1'h0, 1'h1);
        settle();
        chk(q, 9'h000);
        chk({8'h00, ef}, 9'h001);
        u_dcf_peer.rd(1'h0, 1'h0);
        settle();
        chk(q, 9'h1A5);
        u_dcf_peer.rd(1'h0, 1'h0);
        settle();
        chk(q, 9'h05A);
    endtask
    task t_fill;
        int i;
        t_reset(1'h1);
        for (i = 0; i < 256; i++) begin
            u_dcf_peer.wr(i[8:0], 1'h0, 1'h1);
            settle();
            chk({7'h00, ff, af}, {7'h00, i < 255, i < 248});
        end
        u_dcf_peer.wr(9'h1FF, 1'h0, 1'h1);
        for (i = 0; i < 256; i++) begin
            u_dcf_peer.rd(1'h0, 1'h0);
            settle();
            chk(q, i[8:0]);
            chk({8'h00, ae}, {8'h00, i < 248});
            if (i == 0) begin
                u_dcf_peer.wr(9'h000, 1'h1, 1'h1);
                settle();
                chk({8'h00, ff}, 9'h001);
            end
        end
        chk({8'h00, ef}, 9'h000);
    endtask
    task t_flag;
        int i;
        t_reset(1'h0);
        u_dcf_peer.wr(9'h002, 1'h0, 1'h0);
        u_dcf_peer.wr(9'h000, 1'h0, 1'h0);
        u_dcf_peer.wr(9'h003, 1'h0, 1'h0);
        u_dcf_peer.wr(9'h000, 1'h0, 1'h0);
        u_dcf_peer.wr(9'h005, 1'h0, 1'h0);
        u_dcf_peer.wr(9'h0AA, 1'h1, 1'h1);
        for (i = 0; i < 253; i++) begin
            u_dcf_peer.wr(i[8:0], 1'h0, 1'h1);
            u_dcf_peer.rd(1'h1, 1'h1);
            settle();
            chk({7'h00, ae, af}, {7'h00, i > 4, i < 252});
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'h0;
        settle();
        chk({8'h00, oe}, 9'h000);
        @(posedge clock);
        oen <= 1'h0;
        // channel b sees its own reset low at two edges after the global release
        crn_b <= 1'h1;
        settle();
        chk({8'h00, oe}, 9'h001);
        t_twoen();
        t_fill();
        t_flag();
        report_and_stop();
    end
endmodule
`default_nettype wire
